// *** verilog/pulse_accumulator_control.sv ***
// Pulse accumulator, its control register and periodic tick.
//
// Behaviour
// RULE1: control bits 7 and 3 read zero
// RULE2: enable bit zero stops, one runs
// RULE3: mode bit: zero events, one gated
// RULE4: events, edge zero: falling edges count
// RULE5: events, edge one: rising edges count
// RULE6: gated, edge zero: low inhibits counting
// RULE7: gated, edge one: high inhibits counting
// RULE8: gated mode steps on clock/64 ticks
// RULE9: external events no faster than clock/2; the filter needs levels of two clocks, so counts clock/4 at most
// RULE10: counter is eight bits wide
// RULE11: select bit: zero compare five, one capture
// RULE12: periodic tick from clock/8192 base
// RULE13: rate doubles period per step
// RULE14: counter accessible always, reset leaves it
// RULE15: counter readable while gate inactive
// RULE16: increments and reads never collide
// RULE17: overflow flag on wrap, write-one clears
// RULE18: overflow enable raises request, flag untouched
// RULE19: edge flag on selected edge, write-one
// RULE20: edge enable raises request, flag untouched
// RULE21: software clears flag before returning
// RULE22: writing zero leaves flags unchanged
// RULE23: counter keeps counting after wrap
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
module pulse_accumulator_control #(
    parameter int PERIODIC_BASE = pulse_acc_pkg::PERIODIC_BASE_DIV,
    parameter int GATE_DIVIDE   = pulse_acc_pkg::GATE_DIV
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        accumulator_input_i,
    output logic             overflow_irq_o,
    output logic             edge_irq_o,
    output logic             periodic_irq_o,
    output logic             compare_five_en_o,
    output logic             capture_four_en_o
);

    // ****************************************************
    // Elaboration checks.
    // ****************************************************
    // Larger settings would overrun the 16-bit and 8-bit dividers.
    if (PERIODIC_BASE < 2 || PERIODIC_BASE * 8 > 65536) begin : g_bad_base
        $error("PERIODIC_BASE out of range");
    end
    if (GATE_DIVIDE < 2 || GATE_DIVIDE > 256) begin : g_bad_gate
        $error("GATE_DIVIDE out of range");
    end

    // ****************************************************
    // Declarations.
    // ****************************************************
    logic [7:0]  accumulator_control;
    logic [7:0]  accumulator_count;
    logic [7:0]  timer_mask_two;
    logic [7:0]  timer_flag_two;
    logic        overflow_flag;
    logic        edge_flag;
    logic        periodic_flag;
    logic [7:0]  gate_cnt;
    logic        gate_tick;
    logic [15:0] periodic_cnt;
    logic [15:0] periodic_last;
    logic        periodic_tick;
    logic        in_level;
    logic        in_rise;
    logic        in_fall;
    logic        sel_edge;
    logic        count_step;
    logic        overflow_set;
    logic        edge_set;
    logic        access;
    logic        wr_strobe;
    logic        wr_count;
    logic        wr_flag;
    logic [7:0]  wdata;
    logic [7:0]  next_read;

    // ****************************************************
    // Address decode.
    // ****************************************************
    function automatic logic hit(input logic [15:0] adr,
                                 input logic [13:0] idx);
        hit = (adr[15:2] == idx);
    endfunction

    assign access    = cyc_i && stb_i;
    // Writes land on the edge where the master samples ack.
    assign wr_strobe = access && we_i && ack_o && sel_i[0];
    assign wdata     = dat_i[7:0];
    assign wr_count  = wr_strobe
                       && hit(adr_i, pulse_acc_pkg::COUNT_IDX);
    assign wr_flag   = wr_strobe
                       && hit(adr_i, pulse_acc_pkg::FLAG_TWO_IDX);

    // ****************************************************
    // Input synchroniser.
    // ****************************************************
    input_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (accumulator_input_i),
        .level_o (in_level),
        .rise_o  (in_rise),
        .fall_o  (in_fall)
    );

    // Edges closer than two clocks apart are both dropped by the filter.
    // RULE9

    // ****************************************************
    // Gate divider, free running.
    // ****************************************************
    // Running free, the first step after the gate opens may come early.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_cnt  <= 8'h00;
            gate_tick <= 1'b0;
        end else begin
            gate_tick <= (gate_cnt == 8'(GATE_DIVIDE - 1)); // RULE8
            if (gate_cnt == 8'(GATE_DIVIDE - 1)) begin
                gate_cnt <= 8'h00;
            end else begin
                gate_cnt <= gate_cnt + 8'h01;
            end
        end
    end

    // ****************************************************
    // Periodic divider.
    // ****************************************************
    // The period runs from the last timeout, never from a flag clear.
    assign periodic_last = 16'((PERIODIC_BASE
        << accumulator_control[pulse_acc_pkg::RATE_LSB +: 2]) - 1);
    // RULE13

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periodic_cnt  <= 16'h0000;
            periodic_tick <= 1'b0;
        end else begin
            periodic_tick <= (periodic_cnt >= periodic_last); // RULE12
            if (periodic_cnt >= periodic_last) begin
                periodic_cnt <= 16'h0000;
            end else begin
                periodic_cnt <= periodic_cnt + 16'h0001;
            end
        end
    end

    // ****************************************************
    // Counting decision.
    // ****************************************************
    always_comb begin
        sel_edge = accumulator_control[pulse_acc_pkg::EDGE_BIT]
                   ? in_rise                            // RULE5
                   : in_fall;                           // RULE4
        count_step = 1'b0;
        if (accumulator_control[pulse_acc_pkg::ENABLE_BIT]) begin // RULE2
            if (!accumulator_control[pulse_acc_pkg::MODE_BIT]) begin // RULE3
                count_step = sel_edge;
            end else begin
                // Edge bit names the inhibiting level.
                count_step = gate_tick && (in_level
                    ^ accumulator_control[pulse_acc_pkg::EDGE_BIT]);
                // RULE6 RULE7 RULE8
            end
        end
    end

    assign overflow_set = count_step && !wr_count
                          && (accumulator_count == 8'hff); // RULE17
    assign edge_set = sel_edge
        && accumulator_control[pulse_acc_pkg::ENABLE_BIT]; // RULE19

    // ****************************************************
    // Accumulator counter.
    // ****************************************************
    // No reset here: the count survives a reset untouched.
    // A software write in the same cycle wins over a step, so the
    // step and the bus access never act on the same value.
    always_ff @(posedge clk_i) begin // RULE14
        if (wr_count) begin
            accumulator_count <= wdata;
        end else if (count_step) begin // RULE16
            accumulator_count <= accumulator_count + 8'h01; // RULE10 RULE23
        end
    end

    // ****************************************************
    // Control register.
    // ****************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accumulator_control <= pulse_acc_pkg::CONTROL_RESET;
        end else if (wr_strobe
                     && hit(adr_i, pulse_acc_pkg::CONTROL_IDX)) begin
            accumulator_control <= wdata
                                   & pulse_acc_pkg::CONTROL_MASK; // RULE1
        end
    end

    // ****************************************************
    // Interrupt enable register.
    // ****************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_mask_two <= pulse_acc_pkg::MASK_RESET;
        end else if (wr_strobe
                     && hit(adr_i, pulse_acc_pkg::MASK_TWO_IDX)) begin
            timer_mask_two <= 8'h00;
            timer_mask_two[pulse_acc_pkg::PERIODIC_BIT] <=
                wdata[pulse_acc_pkg::PERIODIC_BIT];
            timer_mask_two[pulse_acc_pkg::OVERFLOW_BIT] <=
                wdata[pulse_acc_pkg::OVERFLOW_BIT];
            timer_mask_two[pulse_acc_pkg::EDGE_FLAG_BIT] <=
                wdata[pulse_acc_pkg::EDGE_FLAG_BIT];
        end
    end

    // ****************************************************
    // Flag register.
    // ****************************************************
    // A set arriving with a clear wins, so no event is lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag <=
                pulse_acc_pkg::FLAG_RESET[pulse_acc_pkg::OVERFLOW_BIT];
        end else if (overflow_set) begin
            overflow_flag <= 1'b1; // RULE17
        end else if (wr_flag
                     && wdata[pulse_acc_pkg::OVERFLOW_BIT]) begin
            overflow_flag <= 1'b0; // RULE17 RULE22
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_flag <=
                pulse_acc_pkg::FLAG_RESET[pulse_acc_pkg::EDGE_FLAG_BIT];
        end else if (edge_set) begin
            edge_flag <= 1'b1; // RULE19
        end else if (wr_flag
                     && wdata[pulse_acc_pkg::EDGE_FLAG_BIT]) begin
            edge_flag <= 1'b0; // RULE19 RULE22
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periodic_flag <=
                pulse_acc_pkg::FLAG_RESET[pulse_acc_pkg::PERIODIC_BIT];
        end else if (periodic_tick) begin
            periodic_flag <= 1'b1; // RULE12
        end else if (wr_flag
                     && wdata[pulse_acc_pkg::PERIODIC_BIT]) begin
            periodic_flag <= 1'b0; // RULE22
        end
    end

    // Unimplemented positions read zero.
    always_comb begin
        timer_flag_two = 8'h00;
        timer_flag_two[pulse_acc_pkg::PERIODIC_BIT]  = periodic_flag;
        timer_flag_two[pulse_acc_pkg::OVERFLOW_BIT]  = overflow_flag;
        timer_flag_two[pulse_acc_pkg::EDGE_FLAG_BIT] = edge_flag;
    end

    // ****************************************************
    // Requests and function selects.
    // ****************************************************
    // Requests stay high until software clears the flag or its enable bit.
    // RULE21
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_irq_o    <= 1'b0;
            edge_irq_o        <= 1'b0;
            periodic_irq_o    <= 1'b0;
        end else begin
            overflow_irq_o <=
                timer_flag_two[pulse_acc_pkg::OVERFLOW_BIT]
                && timer_mask_two[pulse_acc_pkg::OVERFLOW_BIT]; // RULE18
            edge_irq_o <=
                timer_flag_two[pulse_acc_pkg::EDGE_FLAG_BIT]
                && timer_mask_two[pulse_acc_pkg::EDGE_FLAG_BIT]; // RULE20
            periodic_irq_o <=
                timer_flag_two[pulse_acc_pkg::PERIODIC_BIT]
                && timer_mask_two[pulse_acc_pkg::PERIODIC_BIT];
        end
    end

    // The two functions share one pin, so exactly one is enabled.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_five_en_o <= 1'b1;
            capture_four_en_o <= 1'b0;
        end else begin
            compare_five_en_o <=
                !accumulator_control[pulse_acc_pkg::CCSEL_BIT]; // RULE11
            capture_four_en_o <=
                accumulator_control[pulse_acc_pkg::CCSEL_BIT]; // RULE11
        end
    end

    // ****************************************************
    // Read multiplexer.
    // ****************************************************
    always_comb begin
        next_read = 8'h00;
        if (hit(adr_i, pulse_acc_pkg::CONTROL_IDX)) begin
            next_read = accumulator_control; // RULE1
        end else if (hit(adr_i, pulse_acc_pkg::COUNT_IDX)) begin
            next_read = accumulator_count; // RULE15
        end else if (hit(adr_i, pulse_acc_pkg::MASK_TWO_IDX)) begin
            next_read = timer_mask_two;
        end else if (hit(adr_i, pulse_acc_pkg::FLAG_TWO_IDX)) begin
            next_read = timer_flag_two;
        end
    end

    // ****************************************************
    // Bus answer.
    // ****************************************************
    // Unmapped addresses are acknowledged and read as zero.
    // Ack is registered, so every access costs one wait state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= access && !ack_o;
            if (access && !ack_o) begin
                dat_o <= {24'h000000, next_read};
            end
        end
    end

endmodule // pulse_accumulator_control

// *** verilog/pulse_acc_pkg.sv ***
// Shared constants for the pulse accumulator control block.
package pulse_acc_pkg;

    // ****************************************************
    // Register indices; byte address is four times these.
    // ****************************************************
    localparam logic [13:0] MASK_TWO_IDX = 14'h1024;
    localparam logic [13:0] FLAG_TWO_IDX = 14'h1025;
    localparam logic [13:0] CONTROL_IDX  = 14'h1026;
    localparam logic [13:0] COUNT_IDX    = 14'h1027;

    // ****************************************************
    // Control register fields.
    // ****************************************************
    localparam int ENABLE_BIT = 6;
    localparam int MODE_BIT   = 5;
    localparam int EDGE_BIT   = 4;
    localparam int CCSEL_BIT  = 2;
    localparam int RATE_LSB   = 0;
    localparam logic [7:0] CONTROL_MASK  = 8'h77;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // ****************************************************
    // Mask and flag register fields.
    // ****************************************************
    localparam int PERIODIC_BIT = 6;
    localparam int OVERFLOW_BIT = 5;
    localparam int EDGE_FLAG_BIT = 4;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] FLAG_RESET = 8'h00;

    // ****************************************************
    // Timing counts in clock cycles.
    // ****************************************************
    localparam int GATE_DIV          = 64;
    localparam int PERIODIC_BASE_DIV = 8192;

endpackage

// *** verilog/input_sync.sv ***
// Three stage input synchroniser with stable level and edge pulses.
`timescale 1ns/1ps
module input_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic       s1;
    logic       s2;
    logic       s3;
    logic [2:0] fill;
    logic       loaded;

    // ****************************************************
    // Synchroniser chain.
    // ****************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // ****************************************************
    // Accepted level and edges.
    // ****************************************************
    // A change is accepted only when the last two stages agree.
    // The level is first loaded once the chain holds real samples, so a
    // pin that idles high shows no false edge after reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fill <= 3'h0;
        end else begin
            fill <= {fill[1:0], 1'b1};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
            loaded  <= 1'b0;
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
        end else begin
            rise_o <= loaded && (s2 == s3) && s3 && !level_o;
            fall_o <= loaded && (s2 == s3) && !s3 && level_o;
            if (fill[2] && (s2 == s3)) begin
                level_o <= s3;
                loaded  <= 1'b1;
            end
        end
    end

endmodule // input_sync

// *** bench/pulse_acc_assertions.sv ***
// Port-level assertions for the pulse accumulator control block.
`timescale 1ns/1ps
module pulse_acc_assertions (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [15:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        accumulator_input_i,
    input wire logic        overflow_irq_o,
    input wire logic        edge_irq_o,
    input wire logic        periodic_irq_o,
    input wire logic        compare_five_en_o,
    input wire logic        capture_four_en_o
);
    // ****************************************************
    // Helpers and defaults.
    // ****************************************************
    logic take;
    logic wr_ack;
    logic ctl_rd;
    assign take   = cyc_i & stb_i & ~ack_o;
    assign wr_ack = ack_o & we_i;
    assign ctl_rd = ack_o & ~we_i
                  & (adr_i[15:2] == pulse_acc_pkg::CONTROL_IDX);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_follows: assert property (take |=> ack_o)
        else $error("request not answered next cycle");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without a request");
    a_data_held: assert property (!$past(take) |-> $stable(dat_o))
        else $error("read data changed without a request");
    a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_ctrl_reserved: assert property (ctl_rd |->
        !dat_o[7] && !dat_o[3])
        else $error("control reserved bits read as one");
    a_select_onehot: assert property (
        compare_five_en_o != capture_four_en_o)
        else $error("compare and capture enables not exclusive");
    a_ovf_hold: assert property ($fell(overflow_irq_o) |->
        $past(wr_ack) || $past(wr_ack, 2))
        else $error("overflow request fell without a write");
    a_edge_hold: assert property ($fell(edge_irq_o) |->
        $past(wr_ack) || $past(wr_ack, 2))
        else $error("edge request fell without a write");
endmodule // pulse_acc_assertions

bind pulse_accumulator_control pulse_acc_assertions pulse_acc_assertions_i (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .accumulator_input_i, .overflow_irq_o, .edge_irq_o,
    .periodic_irq_o, .compare_five_en_o, .capture_four_en_o
);

// *** bench/pulse_source.sv ***
// Behavioural pulse source standing on the accumulator input pin.
`timescale 1ns/1ps
module pulse_source #(
    parameter int HALF = 3
) (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] count_i,
    input  wire logic       idle_i,
    output logic            pin_o,
    output logic            busy_o
);
    // ****************************************************
    // Pulse train; each level lasts HALF cycles, never below two.
    // ****************************************************
    initial begin
        pin_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i) begin
                busy_o <= 1'b1;
                for (int i = 0; i < count_i; i++) begin
                    pin_o <= ~idle_i;
                    repeat (HALF) @(posedge clk_i);
                    pin_o <= idle_i;
                    repeat (HALF) @(posedge clk_i);
                end
                busy_o <= 1'b0;
            end else begin
                pin_o <= idle_i;
            end
        end
    end
endmodule // pulse_source

// *** bench/pulse_accumulator_control_tb.sv ***
// Register-level bench for the pulse accumulator control block.
`timescale 1ns/1ps
module pulse_accumulator_control_tb;
    localparam logic [13:0] MK = pulse_acc_pkg::MASK_TWO_IDX;
    localparam logic [13:0] FG = pulse_acc_pkg::FLAG_TWO_IDX;
    localparam logic [13:0] CT = pulse_acc_pkg::CONTROL_IDX;
    localparam logic [13:0] CN = pulse_acc_pkg::COUNT_IDX;
    localparam int          PBASE = 16;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic        ack, ovf_irq, edge_irq, per_irq, cmp5, cap4, pin, busy;
    logic        go = 1'b0;
    logic        idle = 1'b1;
    logic [7:0]  npulse = 8'h00;
    logic [7:0]  q, r;
    int          errors = 0;
    int          cmp_count = 0;
    int          tick = 0;
    int          t0, t1;

    pulse_accumulator_control #(.PERIODIC_BASE(PBASE), .GATE_DIVIDE(4))
    pulse_accumulator_control_i (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .accumulator_input_i(pin), .overflow_irq_o(ovf_irq),
        .edge_irq_o(edge_irq), .periodic_irq_o(per_irq),
        .compare_five_en_o(cmp5), .capture_four_en_o(cap4));
    pulse_source pulse_source_i (.clk_i(clk_i), .go_i(go),
        .count_i(npulse), .idle_i(idle), .pin_o(pin), .busy_o(busy));

    // ****************************************************
    // Clock, watchdog and shared tasks.
    // ****************************************************
    initial forever #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        tick <= tick + 1;
        if (tick == 20000) begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [13:0] ix,
                      input logic [7:0] d);
        @(posedge clk_i);
        {cyc, stb, we} <= {2'b11, w};
        adr <= {ix, 2'b00};
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        {cyc, stb} <= 2'b00;
    endtask
    task automatic ck(input logic [13:0] ix, input logic [7:0] e);
        wb(1'b0, ix, 8'h00);
        chk(q, e);
    endtask
    // The periodic flag runs free, so bit 6 is left out here.
    task automatic ckf(input logic [7:0] e);
        wb(1'b0, FG, 8'h00);
        chk(q & 8'hbf, e);
    endtask
    task automatic level(input logic lvl);
        idle <= lvl;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic pulses(input logic [7:0] n);
        npulse <= n;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        do begin
            @(posedge clk_i);
        end while (busy === 1'b1);
        repeat (8) @(posedge clk_i);
    endtask
    task automatic wait_per();
        while (per_irq !== 1'b1) begin
            @(posedge clk_i);
        end
    endtask

    // ****************************************************
    // Test sequence.
    // ****************************************************
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        ck(CT, 8'h00);
        ck(FG, 8'h00);
        chk({6'h00, cap4, cmp5}, 8'h01);
        wb(1'b1, CT, 8'hff);
        ck(CT, 8'h77);
        chk({6'h00, cap4, cmp5}, 8'h02);
        ck(14'h0100, 8'h00);
        wb(1'b1, CN, 8'h33);
        sel <= 4'h0;
        wb(1'b1, CN, 8'h55);
        sel <= 4'hf;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        ck(CN, 8'h33);
        ck(CT, 8'h00);
        wb(1'b1, MK, 8'h30);
        wb(1'b1, CT, 8'h40);
        wb(1'b1, CN, 8'hfe);
        pulses(8'd3);
        ck(CN, 8'h01);
        ckf(8'h30);
        chk({6'h00, ovf_irq, edge_irq}, 8'h03);
        wb(1'b1, FG, 8'h00);
        ckf(8'h30);
        wb(1'b1, FG, 8'h20);
        ckf(8'h10);
        wb(1'b1, FG, 8'h10);
        ckf(8'h00);
        chk({6'h00, ovf_irq, edge_irq}, 8'h00);
        wb(1'b1, CT, 8'h00);
        wb(1'b1, MK, 8'h00);
        level(1'b0);
        wb(1'b1, CT, 8'h50);
        wb(1'b1, CN, 8'h00);
        pulses(8'd4);
        ck(CN, 8'h04);
        ckf(8'h10);
        chk({6'h00, ovf_irq, edge_irq}, 8'h00);
        wb(1'b1, FG, 8'h10);
        wb(1'b1, CT, 8'h10);
        pulses(8'd4);
        ck(CN, 8'h04);
        wb(1'b1, CT, 8'h60);
        wb(1'b1, CN, 8'h00);
        level(1'b1);
        repeat (32) @(posedge clk_i);
        level(1'b0);
        wb(1'b0, CN, 8'h00);
        r = q;
        chk({7'h00, r >= 8'd9 && r <= 8'd11}, 8'h01);
        repeat (40) @(posedge clk_i);
        ck(CN, r);
        level(1'b1);
        wb(1'b1, CT, 8'h70);
        wb(1'b1, CN, 8'h00);
        repeat (40) @(posedge clk_i);
        ck(CN, 8'h00);
        level(1'b0);
        repeat (32) @(posedge clk_i);
        level(1'b1);
        wb(1'b0, CN, 8'h00);
        chk({7'h00, q >= 8'd9 && q <= 8'd11}, 8'h01);
        wb(1'b1, FG, 8'h70);
        wb(1'b1, MK, 8'h40);
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, CT, 8'(k));
            wait_per();
            ck(FG, 8'h40);
            wb(1'b1, FG, 8'h40);
            repeat (3) @(posedge clk_i);
            wait_per();
            t0 = tick;
            wb(1'b1, FG, 8'h40);
            repeat (3) @(posedge clk_i);
            wait_per();
            t1 = tick;
            chk(8'(t1 - t0), 8'(PBASE << k));
        end
        end_sim();
    end
endmodule // pulse_accumulator_control_tb
